// >>> hdl/pea_irq_top.v
`timescale 1ns/1ps
`include "pea_consts.vh"
module pea_irq_top #(
  parameter [6:0] DEV_ADDR = `PEA_DEV_ADDR
) (
  input wire mclk,
  input wire reset,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  output reg irq_out_n_o,
  output reg irq_out_n_oe,
  input wire [3:0] pgood_change,
  input wire [3:0] pen_change,
  input wire [3:0] class_done,
  input wire [3:0] detect_done,
  input wire [3:0] disconnect,
  input wire [3:0] overpower_cutoff_flag,
  input wire [3:0] overcurrent_flag,
  input wire [3:0] start_fault,
  input wire [7:0] start_fault_code,
  input wire over_temp,
  input wire logic_rail_low_fail,
  input wire logic_rail_low_warn,
  input wire main_rail_low,
  input wire emergency_off_event,
  input wire [3:0] port_shutdown,
  input wire [3:0] pushbutton_turn_off,
  input wire [3:0] port_restart,
  input wire quad_restart,
  input wire flush_all_flags
);
  // ----------------------------------------
  // bus states, one-hot
  // ----------------------------------------
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_ACK_ADDR = 9'h004;
  localparam [8:0] ST_REG = 9'h008;
  localparam [8:0] ST_ACK_REG = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_ACK_W = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_ACK_R = 9'h100;
  // sticky update: a set in the clearing cycle survives
  function [7:0] next_flags;
    input [7:0] old;
    input [7:0] set;
    input [7:0] clr;
    begin
      next_flags = set | (old & ~clr);
    end
  endfunction

  // ----------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------
  wire [1:0] pins_sync;
  reg scl_d;
  reg sda_d;
  wire scl_s = pins_sync[1];
  wire sda_s = pins_sync[0];
  pea_sync2 #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in({scl_i, sda_i}),
    .sync_out(pins_sync)
  );
  always @(posedge mclk)
  begin
    if (reset)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  // ----------------------------------------
  // event registers
  // ----------------------------------------
  reg [7:0] supply_chg;
  reg [7:0] sense_fin;
  reg [7:0] loss_ovp;
  reg [7:0] ovc_start;
  reg [7:0] rail_alarm;
  reg [7:0] turn_on_code;
  reg [7:0] irq_enable_bits;
  reg [7:0] next_code;
  reg [7:0] rail_set;
  reg [7:0] rd_data;
  wire [7:0] summary;
  wire rd_load;
  reg [7:0] ptr;
  // per-port flush for the fault and done flags
  wire [3:0] port_flush = port_shutdown | pushbutton_turn_off | port_restart |
    {4{quad_restart | flush_all_flags | emergency_off_event}};
  // clear-on-read strobes fire as the byte is fetched for the host
  wire clr_supply = rd_load & (ptr == `PEA_OFS_SUPPLY_CLR);
  wire clr_sense = rd_load & (ptr == `PEA_OFS_SENSE_CLR);
  wire clr_loss = rd_load & (ptr == `PEA_OFS_LOSS_CLR);
  wire clr_ovc = rd_load & (ptr == `PEA_OFS_OVC_CLR);
  wire clr_rail = rd_load & (ptr == `PEA_OFS_RAIL_CLR);
  wire clr_code = rd_load & (ptr == `PEA_OFS_CODE_CLR);
  // supply flags placed at their documented bits
  always @*
  begin
    rail_set = 8'h00;
    rail_set[`PEA_RAIL_OVERTEMP] = over_temp;
    rail_set[`PEA_RAIL_LOGIC_FAIL] = logic_rail_low_fail;
    rail_set[`PEA_RAIL_LOGIC_WARN] = logic_rail_low_warn;
    rail_set[`PEA_RAIL_MAIN_LOW] = main_rail_low;
    rail_set[`PEA_RAIL_EMERG] = emergency_off_event;
  end
  // start fault code fields, two bits per port
  integer p;
  always @*
  begin
    next_code = clr_code ? 8'h00 : turn_on_code;
    for (p = 0; p < 4; p = p + 1)
    begin
      if (start_fault[p])
      begin
        next_code[2*p +: 2] = start_fault_code[2*p +: 2];
      end
    end
  end
  // sticky flags; only a read or a flush command removes them
  always @(posedge mclk)
  begin
    if (reset)
    begin
      supply_chg <= 8'h00;
      sense_fin <= 8'h00;
      loss_ovp <= 8'h00;
      ovc_start <= 8'h00;
      rail_alarm <= 8'h00;
      turn_on_code <= 8'h00;
    end
    else
    begin
      supply_chg <= next_flags(supply_chg, {pgood_change, pen_change}, {8{clr_supply}});
      sense_fin <= next_flags(sense_fin, {class_done, detect_done},
        {8{clr_sense}} | {port_flush, port_flush});
      loss_ovp <= next_flags(loss_ovp, {disconnect, overpower_cutoff_flag},
        {8{clr_loss}} | {port_flush, port_flush});
      ovc_start <= next_flags(ovc_start, {overcurrent_flag, start_fault},
        {8{clr_ovc}} | {port_flush, port_flush});
      rail_alarm <= next_flags(rail_alarm, rail_set, {8{clr_rail}});
      turn_on_code <= next_code;
    end
  end

  // ----------------------------------------
  // summary and interrupt pin
  // ----------------------------------------
  // summary follows its detail flags, so it falls exactly when they are cleared
  assign summary[`PEA_SUM_SUPPLY] = |rail_alarm;
  assign summary[`PEA_SUM_START] = |ovc_start[3:0];
  assign summary[`PEA_SUM_PIFAULT] = (|loss_ovp[3:0]) | (|ovc_start[7:4]);
  assign summary[`PEA_SUM_CLASS] = |sense_fin[7:4];
  assign summary[`PEA_SUM_DETECT] = |sense_fin[3:0];
  assign summary[`PEA_SUM_DISC] = |loss_ovp[7:4];
  assign summary[`PEA_SUM_PGOOD] = |supply_chg[7:4];
  assign summary[`PEA_SUM_PEN] = |supply_chg[3:0];
  // pin only ever pulls low; release comes from the enable alone
  always @(posedge mclk)
  begin
    if (reset)
    begin
      irq_out_n_o <= 1'b0;
      irq_out_n_oe <= 1'b0;
    end
    else
    begin
      irq_out_n_o <= 1'b0;
      irq_out_n_oe <= |(summary & irq_enable_bits);
    end
  end

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always @*
  begin
    case (ptr)
      `PEA_OFS_SUMMARY: rd_data = summary;
      `PEA_OFS_MASK: rd_data = irq_enable_bits;
      `PEA_OFS_SUPPLY_VIEW, `PEA_OFS_SUPPLY_CLR: rd_data = supply_chg;
      `PEA_OFS_SENSE_VIEW, `PEA_OFS_SENSE_CLR: rd_data = sense_fin;
      `PEA_OFS_LOSS_VIEW, `PEA_OFS_LOSS_CLR: rd_data = loss_ovp;
      `PEA_OFS_OVC_VIEW, `PEA_OFS_OVC_CLR: rd_data = ovc_start;
      `PEA_OFS_RAIL_VIEW, `PEA_OFS_RAIL_CLR: rd_data = rail_alarm;
      `PEA_OFS_CODE_VIEW, `PEA_OFS_CODE_CLR: rd_data = turn_on_code;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // serial bus slave
  // ----------------------------------------
  reg [8:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg rw_bit;
  reg load_req;
  // a byte is fetched for the host one cycle after the falling edges named below
  assign rd_load = load_req;
  // the slave only answers; it never drives the clock or a start
  always @(posedge mclk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      rw_bit <= 1'b0;
      ptr <= 8'h00;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      irq_enable_bits <= `PEA_MASK_RESET;
      load_req <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      load_req <= 1'b0;
      if (load_req)
      begin
        // fetch happened this cycle; drive its first bit
        shreg <= rd_data;
        sda_oe <= ~rd_data[7];
        ptr <= ptr + 8'h01;
        bitcnt <= 4'h0;
        state <= ST_RDATA;
      end
      else if (bus_start)
      begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state)
          ST_ADDR, ST_REG, ST_WDATA:
          begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          ST_RDATA:
            bitcnt <= bitcnt + 4'h1;
          ST_ACK_R:
            if (sda_s)
              state <= ST_IDLE; // host nack ends the read
          default:
            bitcnt <= bitcnt;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          ST_ADDR:
            if (bitcnt == `PEA_BYTE_BITS)
            begin
              if (shreg[7:1] == DEV_ADDR)
              begin
                rw_bit <= shreg[0];
                sda_oe <= 1'b1;
                state <= ST_ACK_ADDR;
              end
              else
                state <= ST_IDLE;
            end
          ST_ACK_ADDR:
          begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            if (rw_bit)
              load_req <= 1'b1;
            else
              state <= ST_REG;
          end
          ST_REG:
            if (bitcnt == `PEA_BYTE_BITS)
            begin
              ptr <= shreg;
              sda_oe <= 1'b1;
              state <= ST_ACK_REG;
            end
          ST_ACK_REG, ST_ACK_W:
          begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            state <= ST_WDATA;
          end
          ST_WDATA:
            if (bitcnt == `PEA_BYTE_BITS)
            begin
              if (ptr == `PEA_OFS_MASK)
                irq_enable_bits <= shreg;
              ptr <= ptr + 8'h01;
              sda_oe <= 1'b1;
              state <= ST_ACK_W;
            end
          ST_RDATA:
            if (bitcnt == `PEA_BYTE_BITS)
            begin
              sda_oe <= 1'b0;
              state <= ST_ACK_R;
            end
            else
            begin
              sda_oe <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
            end
          ST_ACK_R:
            load_req <= 1'b1;
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule

// >>> hdl/pea_consts.vh
// Functional notes
// - any detail flag raises its summary group
// - interrupt only when summary and mask agree
// - interrupt pin is open-drain, wire-or capable
// - device only signals, never starts transfers
// - event flags sticky until host reads them
// - summary cleared only by reading mapped register or by a flush command
// - new events after read set flags again
// - start fault also stores per-port code
// - start summary cleared by start register read
// - port and global commands also clear flags
// - summary and mask share one bit layout
// - detail registers: view plus clear-on-read pairs
// - supply register bit layout
`ifndef PEA_CONSTS_VH
`define PEA_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PEA_OFS_SUMMARY 8'h00
`define PEA_OFS_MASK 8'h01
`define PEA_OFS_SUPPLY_VIEW 8'h02
`define PEA_OFS_SUPPLY_CLR 8'h03
`define PEA_OFS_SENSE_VIEW 8'h04
`define PEA_OFS_SENSE_CLR 8'h05
`define PEA_OFS_LOSS_VIEW 8'h06
`define PEA_OFS_LOSS_CLR 8'h07
`define PEA_OFS_OVC_VIEW 8'h08
`define PEA_OFS_OVC_CLR 8'h09
`define PEA_OFS_RAIL_VIEW 8'h0A
`define PEA_OFS_RAIL_CLR 8'h0B
`define PEA_OFS_CODE_VIEW 8'h24
`define PEA_OFS_CODE_CLR 8'h25

// ----------------------------------------
// summary bit positions (mask uses the same)
// ----------------------------------------
`define PEA_SUM_SUPPLY 7
`define PEA_SUM_START 6
`define PEA_SUM_PIFAULT 5
`define PEA_SUM_CLASS 4
`define PEA_SUM_DETECT 3
`define PEA_SUM_DISC 2
`define PEA_SUM_PGOOD 1
`define PEA_SUM_PEN 0

// ----------------------------------------
// supply register bit positions
// ----------------------------------------
`define PEA_RAIL_OVERTEMP 7
`define PEA_RAIL_LOGIC_FAIL 6
`define PEA_RAIL_LOGIC_WARN 5
`define PEA_RAIL_MAIN_LOW 4
`define PEA_RAIL_EMERG 0

// ----------------------------------------
// reset values and defaults
// ----------------------------------------
`define PEA_MASK_RESET 8'h00
`define PEA_DEV_ADDR 7'h20
`define PEA_BYTE_BITS 4'h8

`endif

// >>> hdl/pea_sync2.v
`timescale 1ns/1ps
// ----------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------
module pea_sync2 #(
  parameter W = 2
) (
  input wire mclk,
  input wire reset,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge mclk)
  begin
    if (reset)
    begin
      meta <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> sim/pea_irq_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// pin checker
// ----------------------------------------
module pea_irq_chk (
  input wire mclk,
  input wire reset,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe,
  input wire irq_out_n_o,
  input wire irq_out_n_oe,
  input wire [3:0] pgood_change,
  input wire [3:0] pen_change,
  input wire [3:0] class_done,
  input wire [3:0] detect_done,
  input wire [3:0] disconnect,
  input wire [3:0] overpower_cutoff_flag,
  input wire [3:0] overcurrent_flag,
  input wire [3:0] start_fault,
  input wire over_temp,
  input wire logic_rail_low_fail,
  input wire logic_rail_low_warn,
  input wire main_rail_low,
  input wire emergency_off_event,
  input wire [3:0] port_shutdown,
  input wire [3:0] pushbutton_turn_off,
  input wire [3:0] port_restart,
  input wire quad_restart,
  input wire flush_all_flags
);
  wire ev_any = |{pgood_change, pen_change, class_done, detect_done, disconnect, overpower_cutoff_flag,
    overcurrent_flag, start_fault, over_temp, logic_rail_low_fail, logic_rail_low_warn, main_rail_low,
    emergency_off_event};
  wire fl_any = |{port_shutdown, pushbutton_turn_off, port_restart, quad_restart, flush_all_flags,
    emergency_off_event};
  logic scl_d = 1'b1;
  int sq = 0;
  int fq = 0;
  // quiet counters: a read can only clear flags just after the bus clock moves
  always @(posedge mclk)
  begin
    scl_d <= scl_i;
    sq <= (scl_i != scl_d) ? 0 : ((sq < 20) ? sq + 1 : sq);
    fq <= fl_any ? 0 : ((fq < 9) ? fq + 1 : fq);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_quiet;
    sq >= 8 && fq >= 3;
  endsequence
  sequence s_release;
    $fell(reset);
  endsequence
  AST_IRQ_LOW: assert property (irq_out_n_o == 1'b0) else $error("irq value not low");
  AST_SDA_LOW: assert property (sda_o == 1'b0) else $error("data value not low");
  AST_RST_IDLE: assert property (s_release |-> (!irq_out_n_oe && !sda_oe) [*2]) else $error("pins busy");
  AST_RISE: assert property ($rose(irq_out_n_oe) |-> $past(ev_any, 2) || sq < 8) else $error("irq no cause");
  AST_STICKY: assert property (irq_out_n_oe ##0 s_quiet |=> irq_out_n_oe) else $error("irq lost");
  AST_FALL: assert property ($fell(irq_out_n_oe) |-> sq < 9 || fq < 4 || $past(reset)) else $error("fall");
  AST_SDA_CHG: assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved, clock high");
  AST_ACK_SPAN: assert property ($rose(sda_oe) |-> !scl_i [*2]) else $error("drive too late");
endmodule
bind pea_irq_top pea_irq_chk pea_irq_chk_inst (.*);

// >>> sim/pea_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// host on the two-wire bus
// ----------------------------------------
module pea_host #(
  parameter [6:0] ADR = 7'h20,
  parameter real Q = 31.25
) (
  output logic scl,
  output logic pull,
  input wire sda
);
  // clock stands high between frames, data left to the pull-up
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    #Q pull = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // waits a half low phase so the device has let go of its ack
  task automatic sta;
    #Q pull = 1'b0;
    #Q scl = 1'b1;
    #Q pull = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic sto;
    #Q pull = 1'b1;
    #Q scl = 1'b1;
    #Q pull = 1'b0;
    #Q;
  endtask
  task automatic xb(input logic [7:0] b, input logic last, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r[i]);
    bitx(last, a);
  endtask
  // each transfer starts 2 ns past a falling edge, so no pin ever moves on an mclk edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    #2;
    sta;
    xb({ADR, 1'b0}, 1'b1, r);
    xb(a, 1'b1, r);
    sta;
    xb({ADR, 1'b1}, 1'b1, r);
    xb(8'hFF, 1'b1, d);
    sto;
  endtask
  // two bytes in one read; the ack after the first makes the device fetch the next offset
  task automatic rd2(input logic [6:0] ad, input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] r;
    #2;
    sta;
    xb({ad, 1'b0}, 1'b1, r);
    xb(a, 1'b1, r);
    sta;
    xb({ad, 1'b1}, 1'b1, r);
    xb(8'hFF, 1'b0, d0);
    xb(8'hFF, 1'b1, d1);
    sto;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    #2;
    sta;
    xb({ADR, 1'b0}, 1'b1, r);
    xb(a, 1'b1, r);
    xb(v, 1'b1, r);
    sto;
  endtask
endmodule

// >>> sim/test_pea_irq_top.sv
`timescale 1ns/1ps
module test_pea_irq_top;
  logic mclk, reset, pull;
  logic [43:0] evt;
  logic [13:0] fl;
  logic [7:0] code, mk, a;
  logic [7:0] m [0:5];
  logic [15:0] lf;
  int fail_count, n_checks, cyc;
  wire scl, sda_o, sda_oe, irq_o, irq_oe;
  wire sda = ~(pull | sda_oe);
  wire irq_line = ~irq_oe;
  pea_irq_top pea_irq_top_inst (
    .mclk(mclk),
    .reset(reset),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .irq_out_n_o(irq_o),
    .irq_out_n_oe(irq_oe),
    .pgood_change(evt[7:4]),
    .pen_change(evt[3:0]),
    .class_done(evt[15:12]),
    .detect_done(evt[11:8]),
    .disconnect(evt[23:20]),
    .overpower_cutoff_flag(evt[19:16]),
    .overcurrent_flag(evt[31:28]),
    .start_fault(evt[27:24]),
    .start_fault_code(code),
    .over_temp(evt[39]),
    .logic_rail_low_fail(evt[38]),
    .logic_rail_low_warn(evt[37]),
    .main_rail_low(evt[36]),
    .emergency_off_event(evt[32]),
    .port_shutdown(fl[3:0]),
    .pushbutton_turn_off(fl[7:4]),
    .port_restart(fl[11:8]),
    .quad_restart(fl[12]),
    .flush_all_flags(fl[13])
  );
  pea_host pea_host_inst (
    .scl(scl),
    .pull(pull),
    .sda(sda)
  );
  // ----------------------------------------
  // clock, timeout, reporting
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail_count++;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t reg %h exp %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t irq line %b exp %b", $time, g, e);
    end
  endtask
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [15:0] nx(input logic [15:0] x);
    nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] sum();
    sum = {|m[4], |m[3][3:0], |m[2][3:0] | |m[3][7:4], |m[1][7:4], |m[1][3:0], |m[2][7:4], |m[0][7:4], |m[0][3:0]};
  endfunction
  // one-cycle pulse; a set in the same cycle beats a flush
  task pulse(input logic [43:0] e, input logic [13:0] f);
    logic [3:0] p;
    p = f[3:0] | f[7:4] | f[11:8] | {4{f[12] | f[13] | e[32]}};
    @(negedge mclk);
    evt = e;
    fl = f;
    @(negedge mclk);
    evt = 44'h0;
    fl = 14'h0;
    for (int k = 1; k < 4; k++)
      m[k] = m[k] & ~{p, p};
    for (int k = 0; k < 4; k++)
      m[k] = m[k] | e[8*k+:8];
    m[4] = m[4] | (e[39:32] & 8'hF1);
    for (int n = 0; n < 4; n++)
      if (e[24+n])
        m[5][2*n+:2] = code[2*n+:2];
  endtask
  task rdc(input logic [7:0] r);
    logic [7:0] e, v;
    e = (r == 8'h00) ? sum() : (r == 8'h01) ? mk : (r >= 8'h02 && r <= 8'h0B) ? m[(r-8'h02)>>1] :
      (r == 8'h24 || r == 8'h25) ? m[5] : 8'h00;
    @(negedge mclk);
    pea_host_inst.rd(r, v);
    chk8(v, e);
    if (r[0] && r > 8'h01)
      m[(r == 8'h25) ? 5 : (r-8'h02)>>1] = 8'h00;
  endtask
  // burst of view then clear; a foreign address gets no answer and reads as pull-up
  task rdb(input logic [6:0] ad, input logic [7:0] r);
    logic [7:0] e, v0, v1;
    e = (ad == pea_host_inst.ADR) ? m[(r-8'h02)>>1] : 8'hFF;
    @(negedge mclk);
    pea_host_inst.rd2(ad, r, v0, v1);
    chk8(v0, e);
    chk8(v1, e);
    if (ad == pea_host_inst.ADR)
      m[(r-8'h02)>>1] = 8'h00;
  endtask
  task ir;
    repeat (3) @(negedge mclk);
    chk1(irq_line, ~|(sum() & mk));
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    evt = 44'h0;
    fl = 14'h0;
    code = 8'h00;
    mk = 8'h00;
    reset = 1'b1;
    lf = 16'h78E0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    for (int i = 0; i < 6; i++)
      m[i] = 8'h00;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    rdc(8'h00);
    rdc(8'h01);
    rdc(8'h10);
    ir;
    pea_host_inst.wr(8'h01, 8'hFF);
    mk = 8'hFF;
    rdc(8'h01);
    // a write to the read-only summary is taken and ignored
    @(negedge mclk);
    pea_host_inst.wr(8'h00, 8'h5A);
    rdc(8'h01);
    // every event group and rail bit: view keeps, clear-on-read clears
    for (int k = 0; k < 9; k++)
    begin
      lf = nx(lf);
      code = lf[15:8];
      pulse((k < 8) ? (44'h1 | lf[3:0]) << (4 * k) : 44'h0F100000000, 14'h0);
      ir;
      a = 8'h02 + {4'h0, k[3:1], 1'b0};
      rdc(8'h00);
      rdc(a);
      rdc(a + 8'h01);
      rdc(a);
      rdc(8'h00);
      ir;
    end
    pea_host_inst.wr(8'h01, 8'h08);
    mk = 8'h08;
    pulse(44'h3000, 14'h0);
    ir;
    pulse(44'h100, 14'h0);
    ir;
    rdc(8'h05);
    ir;
    pea_host_inst.wr(8'h01, 8'hFF);
    mk = 8'hFF;
    code = 8'hB4;
    pulse(44'hF000000, 14'h0);
    rdc(8'h24);
    rdc(8'h09);
    rdc(8'h00);
    rdc(8'h24);
    code = 8'h4E;
    pulse(44'h2000000, 14'h0);
    ir;
    rdc(8'h24);
    rdc(8'h25);
    rdc(8'h24);
    // each flush command on top of full flag sets
    for (int j = 0; j < 6; j++)
    begin
      lf = nx(lf);
      pulse(44'h000FFFFFF00, 14'h0);
      pulse((j == 5) ? 44'h100000000 : 44'h0, (j < 3) ? {10'h0, lf[3:0]} << (4 * j) : (j < 5) ? 14'h1000 << (j - 3) : 14'h0);
      rdc(8'h04);
      rdc(8'h06);
      rdc(8'h08);
      rdc(8'h0B);
      rdc(8'h00);
    end
    // another address stays silent; an acked burst reads the view, then clears it
    pulse(44'hA500, 14'h0);
    rdb(pea_host_inst.ADR ^ 7'h01, 8'h04);
    rdb(pea_host_inst.ADR, 8'h04);
    rdc(8'h04);
    rdc(8'h00);
    summarize;
  end
endmodule
